//--- pkg/dgcs_defs.vh
// Constants for the shared global configuration and status register bank
`ifndef DGCS_DEFS_VH
`define DGCS_DEFS_VH

// Register offsets
`define DGCS_OFS_GEN_CFG 8'h02
`define DGCS_OFS_REV 8'h03
`define DGCS_OFS_STATUS 8'h04
`define DGCS_OFS_THR_HI 8'h05
`define DGCS_OFS_THR_LO 8'h06

// General configuration field positions
`define DGCS_CFG_PROXY_BIT 5
`define DGCS_CFG_OEN_MODE_BIT 4
`define DGCS_CFG_OUT_EN_BIT 3
`define DGCS_CFG_SLEEP_SEL_BIT 2
`define DGCS_CFG_PAR_EN_BIT 1
`define DGCS_CFG_REF_OVR_BIT 0

// Status field positions
`define DGCS_STS_CKSUM_BIT 7
`define DGCS_STS_INIT_BIT 6
`define DGCS_STS_RSV5_BIT 5
`define DGCS_STS_REF_BIT 4
`define DGCS_STS_PASS_BIT 3
`define DGCS_STS_LOCK_BIT 2
`define DGCS_STS_RSV_LO 2'h3

// Reset values
`define DGCS_RST_GEN_CFG 8'h1e
`define DGCS_RST_THR_HI 8'h01
`define DGCS_RST_THR_LO 8'h00
`define DGCS_RST_MASK_REV 4'h0
`define DGCS_UNMAPPED_READ 8'h00

// Reference clock frequency limits and measuring window
`define DGCS_CLK_PERIOD_NS 20
`define DGCS_REF_MIN_MHZ 12
`define DGCS_REF_MAX_MHZ 64
`define DGCS_REF_PIN_DIV 4
`define DGCS_REF_WIN_NS 10000
`define DGCS_REF_WIN_CYC (`DGCS_REF_WIN_NS / `DGCS_CLK_PERIOD_NS)
`define DGCS_REF_MIN_EDGES \
	((`DGCS_REF_MIN_MHZ * `DGCS_REF_WIN_NS + 1000 * `DGCS_REF_PIN_DIV - 1) \
	/ (1000 * `DGCS_REF_PIN_DIV))
`define DGCS_REF_MAX_EDGES \
	((`DGCS_REF_MAX_MHZ * `DGCS_REF_WIN_NS) / (1000 * `DGCS_REF_PIN_DIV))
// Sized forms of the window end and the edge limits above
`define DGCS_REF_WIN_LAST 9'h1f3
`define DGCS_REF_MIN_CNT 8'h1e
`define DGCS_REF_MAX_CNT 8'ha0

`endif

//--- verilog/dgcs_par_limit.v
// Per-port parity error counter with threshold flag
`timescale 1ns/1ps
module dgcs_par_limit (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Control from the register bank
	input wire check_en,
	input wire [15:0] parity_error_limit,
	// Receiver events
	input wire parity_err,
	input wire count_clear,
	// Result
	output reg limit_flag,
	output reg [15:0] err_count
);

	wire [15:0] count_next;
	wire flag_next;

	// Saturate so a long error burst never wraps back under the limit
	assign count_next = (!check_en) ? err_count :
		(parity_err && err_count != 16'hffff) ?
		err_count + 16'h0001 : err_count;

	assign flag_next = (count_next >= parity_error_limit);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			err_count <= 16'h0000;
			limit_flag <= 1'b0;
		end else if (count_clear) begin
			// A clear restarts counting; a same-cycle error is kept
			err_count <= (check_en && parity_err) ? 16'h0001 : 16'h0000;
			limit_flag <= 1'b0;
		end else begin
			err_count <= count_next;
			limit_flag <= flag_next;
		end
	end

endmodule

//--- verilog/dgcs_top.v
// Shared global configuration and status register bank
//
// Notes on behaviour
// - Proxy master access allowed only when bit set
// - Mode zero and no lock: CSI high impedance
// - Mode one, no lock, sleep select one, enable one: CSI in LP-11
// - Sleep select one, enable zero: high impedance
// - Mode one, lock low, sleep select zero: drive HS-0
// - Parity checker runs only when enabled
// - Override forces reference clock reported present
// - Checksum good set after valid config load
// - Load complete set after power-up initialization
// - Frequency bit set within 12 to 64 MHz
// - Pass status mirrors the pass pin
// - Lock status mirrors the lock pin
// - Per-port flag when errors reach threshold
// - Threshold from high and low byte registers
// - Revision register holds silicon and mask nibbles
// - Registers reachable from local and remote hosts
// - Load complete also marks restarted autoload end
`timescale 1ns/1ps
`include "dgcs_defs.vh"
module dgcs_top #(
	// Silicon revision nibble; value is arbitrary
	parameter [3:0] SILICON_REV = 4'h5
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Local I2C host register port
	input wire lcl_req,
	input wire lcl_write,
	input wire [7:0] lcl_addr,
	input wire [7:0] lcl_wdata,
	output reg lcl_ack,
	output reg [7:0] lcl_rdata,
	// Remote host register port over the control channel
	input wire rmt_req,
	input wire rmt_write,
	input wire [7:0] rmt_addr,
	input wire [7:0] rmt_wdata,
	output reg rmt_ack,
	output reg [7:0] rmt_rdata,
	// Receiver pins and status from outside the clock domain
	input wire [1:0] rx_lock,
	input wire [1:0] rx_pass,
	input wire refclk_detect,
	input wire refclk_div,
	// Receiver events on this clock
	input wire [1:0] rx_parity_err,
	input wire [1:0] rx_status_clear,
	input wire [1:0] csi_port_assign,
	// Configuration loader
	input wire autoload_restart,
	input wire cfg_load_done,
	input wire cfg_cksum_ok,
	output reg autoload_run,
	// Control and indication outputs
	output reg proxy_master_allow,
	output reg parity_check_en,
	output reg refclk_present,
	output reg lock_pin,
	output reg pass_pin,
	output reg csi_tx_hiz,
	output reg csi_tx_hs0,
	output reg csi_tx_lp11,
	output reg [1:0] parity_limit_flag
);

	// Loader states, one-hot
	localparam [1:0] ST_LOAD = 2'b01;
	localparam [1:0] ST_DONE = 2'b10;

	reg [7:0] gen_cfg_reg;
	reg [7:0] thr_hi_reg;
	reg [7:0] thr_lo_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg cksum_reg;
	reg ref_ok_reg;
	reg [3:0] sync1_lock_reg;
	reg [3:0] sync2_lock_reg;
	reg [1:0] sync1_ref_reg;
	reg [1:0] sync2_ref_reg;
	reg ref_prev_reg;
	reg [8:0] win_cnt_reg;
	reg [7:0] edge_cnt_reg;
	reg rmt_pend_reg;
	reg rmt_wr_hold_reg;
	reg [7:0] rmt_addr_hold_reg;
	reg [7:0] rmt_wdata_hold_reg;

	wire [1:0] lock_s;
	wire [1:0] pass_s;
	wire ref_det_s;
	wire ref_div_s;
	wire any_lock;
	wire [15:0] parity_error_limit;
	wire rmt_go;
	wire rmt_wr_eff;
	wire [7:0] rmt_addr_eff;
	wire [7:0] rmt_wdata_eff;
	wire win_end;
	wire ref_edge;
	wire [7:0] status_val;
	wire [7:0] rev_val;
	wire [1:0] flag_w;
	reg [7:0] lcl_rd_mux;
	reg [7:0] rmt_rd_mux;
	reg wr_en;
	reg [7:0] wr_addr;
	reg [7:0] wr_data;

	// Two-flop synchronisers for every pin input
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_lock_reg <= 4'h0;
			sync2_lock_reg <= 4'h0;
			sync1_ref_reg <= 2'h0;
			sync2_ref_reg <= 2'h0;
		end else begin
			sync1_lock_reg <= {rx_pass, rx_lock};
			sync2_lock_reg <= sync1_lock_reg;
			sync1_ref_reg <= {refclk_div, refclk_detect};
			sync2_ref_reg <= sync1_ref_reg;
		end
	end

	assign lock_s = sync2_lock_reg[1:0];
	assign pass_s = sync2_lock_reg[3:2];
	assign ref_det_s = sync2_ref_reg[0];
	assign ref_div_s = sync2_ref_reg[1];

	// Only receivers assigned to the CSI port count toward its lock
	assign any_lock = |(lock_s & csi_port_assign);

	assign parity_error_limit = {thr_hi_reg, thr_lo_reg};

	assign rev_val = {SILICON_REV, `DGCS_RST_MASK_REV};

	assign status_val = {cksum_reg, state_reg == ST_DONE, 1'b0,
		ref_ok_reg, pass_pin, lock_pin, `DGCS_STS_RSV_LO};

	// Remote access waits for a cycle with no local request when it collides with local
	assign rmt_go = !lcl_req && (rmt_req || rmt_pend_reg);
	assign rmt_wr_eff = rmt_pend_reg ? rmt_wr_hold_reg : rmt_write;
	assign rmt_addr_eff = rmt_pend_reg ? rmt_addr_hold_reg : rmt_addr;
	assign rmt_wdata_eff = rmt_pend_reg ? rmt_wdata_hold_reg : rmt_wdata;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rmt_pend_reg <= 1'b0;
			rmt_wr_hold_reg <= 1'b0;
			rmt_addr_hold_reg <= 8'h00;
			rmt_wdata_hold_reg <= 8'h00;
		end else if (lcl_req && rmt_req && !rmt_pend_reg) begin
			rmt_pend_reg <= 1'b1;
			rmt_wr_hold_reg <= rmt_write;
			rmt_addr_hold_reg <= rmt_addr;
			rmt_wdata_hold_reg <= rmt_wdata;
		end else if (rmt_go) begin
			rmt_pend_reg <= 1'b0;
		end
	end

	// One write port shared by both hosts, local first
	always @* begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		if (lcl_req && lcl_write) begin
			wr_en = 1'b1;
			wr_addr = lcl_addr;
			wr_data = lcl_wdata;
		end else if (rmt_go && rmt_wr_eff) begin
			wr_en = 1'b1;
			wr_addr = rmt_addr_eff;
			wr_data = rmt_wdata_eff;
		end
	end

	// Writable registers; status and revision ignore writes
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			gen_cfg_reg <= `DGCS_RST_GEN_CFG;
			thr_hi_reg <= `DGCS_RST_THR_HI;
			thr_lo_reg <= `DGCS_RST_THR_LO;
		end else if (wr_en) begin
			case (wr_addr)
			`DGCS_OFS_GEN_CFG: begin
				gen_cfg_reg <= wr_data;
			end
			`DGCS_OFS_THR_HI: begin
				thr_hi_reg <= wr_data;
			end
			`DGCS_OFS_THR_LO: begin
				thr_lo_reg <= wr_data;
			end
			default: begin
				gen_cfg_reg <= gen_cfg_reg;
			end
			endcase
		end
	end

	// Read data for the local host
	always @* begin
		case (lcl_addr)
		`DGCS_OFS_GEN_CFG: lcl_rd_mux = gen_cfg_reg;
		`DGCS_OFS_REV: lcl_rd_mux = rev_val;
		`DGCS_OFS_STATUS: lcl_rd_mux = status_val;
		`DGCS_OFS_THR_HI: lcl_rd_mux = thr_hi_reg;
		`DGCS_OFS_THR_LO: lcl_rd_mux = thr_lo_reg;
		default: lcl_rd_mux = `DGCS_UNMAPPED_READ;
		endcase
	end

	// Read data for the remote host
	always @* begin
		case (rmt_addr_eff)
		`DGCS_OFS_GEN_CFG: rmt_rd_mux = gen_cfg_reg;
		`DGCS_OFS_REV: rmt_rd_mux = rev_val;
		`DGCS_OFS_STATUS: rmt_rd_mux = status_val;
		`DGCS_OFS_THR_HI: rmt_rd_mux = thr_hi_reg;
		`DGCS_OFS_THR_LO: rmt_rd_mux = thr_lo_reg;
		default: rmt_rd_mux = `DGCS_UNMAPPED_READ;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			lcl_ack <= 1'b0;
			lcl_rdata <= 8'h00;
			rmt_ack <= 1'b0;
			rmt_rdata <= 8'h00;
		end else begin
			lcl_ack <= lcl_req;
			rmt_ack <= rmt_go;
			if (lcl_req) begin
				lcl_rdata <= lcl_rd_mux;
			end
			if (rmt_go) begin
				rmt_rdata <= rmt_rd_mux;
			end
		end
	end

	// Loader sequencing, restart drops the done indication
	always @* begin
		case (state_reg)
		ST_LOAD: begin
			state_next = cfg_load_done ? ST_DONE : ST_LOAD;
		end
		ST_DONE: begin
			state_next = autoload_restart ? ST_LOAD : ST_DONE;
		end
		default: begin
			state_next = ST_LOAD;
		end
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_LOAD;
			cksum_reg <= 1'b0;
			autoload_run <= 1'b1;
		end else begin
			state_reg <= state_next;
			autoload_run <= (state_next == ST_LOAD);
			if (state_reg == ST_LOAD && cfg_load_done) begin
				cksum_reg <= cfg_cksum_ok;
			end else if (state_next == ST_LOAD) begin
				cksum_reg <= 1'b0;
			end
		end
	end

	// Window timer for the reference frequency check
	assign win_end = (win_cnt_reg == `DGCS_REF_WIN_LAST);
	assign ref_edge = ref_div_s && !ref_prev_reg;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ref_prev_reg <= 1'b0;
			win_cnt_reg <= 9'h000;
			edge_cnt_reg <= 8'h00;
			ref_ok_reg <= 1'b0;
		end else begin
			ref_prev_reg <= ref_div_s;
			if (win_end) begin
				win_cnt_reg <= 9'h000;
				edge_cnt_reg <= 8'h00;
				ref_ok_reg <= (edge_cnt_reg >= `DGCS_REF_MIN_CNT)
					&& (edge_cnt_reg <= `DGCS_REF_MAX_CNT);
			end else begin
				win_cnt_reg <= win_cnt_reg + 9'h001;
				// Saturate so a runaway input never wraps into range
				if (ref_edge && edge_cnt_reg != 8'hff) begin
					edge_cnt_reg <= edge_cnt_reg + 8'h01;
				end
			end
		end
	end

	// Control outputs and pin levels, all registered
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			proxy_master_allow <= 1'b0;
			parity_check_en <= 1'b1;
			refclk_present <= 1'b0;
			lock_pin <= 1'b0;
			pass_pin <= 1'b0;
		end else begin
			proxy_master_allow <= gen_cfg_reg[`DGCS_CFG_PROXY_BIT];
			parity_check_en <= gen_cfg_reg[`DGCS_CFG_PAR_EN_BIT];
			refclk_present <= gen_cfg_reg[`DGCS_CFG_REF_OVR_BIT]
				| ref_det_s;
			lock_pin <= |lock_s;
			pass_pin <= |(pass_s & lock_s);
		end
	end

	// CSI output drive policy; high impedance beats every other state
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			csi_tx_hiz <= 1'b1;
			csi_tx_hs0 <= 1'b0;
			csi_tx_lp11 <= 1'b0;
		end else begin
			csi_tx_hiz <= 1'b0;
			csi_tx_hs0 <= 1'b0;
			csi_tx_lp11 <= 1'b0;
			if (!gen_cfg_reg[`DGCS_CFG_OEN_MODE_BIT] && !any_lock) begin
				csi_tx_hiz <= 1'b1;
			end else if (gen_cfg_reg[`DGCS_CFG_SLEEP_SEL_BIT] &&
				!gen_cfg_reg[`DGCS_CFG_OUT_EN_BIT]) begin
				csi_tx_hiz <= 1'b1;
			end else if (!any_lock &&
				!gen_cfg_reg[`DGCS_CFG_SLEEP_SEL_BIT]) begin
				csi_tx_hs0 <= 1'b1;
			end else if (!any_lock) begin
				csi_tx_lp11 <= 1'b1;
			end
		end
	end

	dgcs_par_limit u_par0 (
		.clk(clk),
		.reset(reset),
		.check_en(gen_cfg_reg[`DGCS_CFG_PAR_EN_BIT]),
		.parity_error_limit(parity_error_limit),
		.parity_err(rx_parity_err[0]),
		.count_clear(rx_status_clear[0]),
		.limit_flag(flag_w[0]),
		.err_count()
	);

	dgcs_par_limit u_par1 (
		.clk(clk),
		.reset(reset),
		.check_en(gen_cfg_reg[`DGCS_CFG_PAR_EN_BIT]),
		.parity_error_limit(parity_error_limit),
		.parity_err(rx_parity_err[1]),
		.count_clear(rx_status_clear[1]),
		.limit_flag(flag_w[1]),
		.err_count()
	);

	// Flags leave through a flop of this module
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			parity_limit_flag <= 2'b00;
		end else begin
			parity_limit_flag <= flag_w;
		end
	end

endmodule

//--- test/dgcs_top_sva.sv
// Port assertions for the shared configuration and status register bank
`timescale 1ns/1ps
module dgcs_top_sva (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Register ports
	input wire lcl_req,
	input wire lcl_write,
	input wire [7:0] lcl_addr,
	input wire [7:0] lcl_wdata,
	input wire lcl_ack,
	input wire rmt_req,
	input wire rmt_ack,
	// Pins and loader
	input wire [1:0] rx_lock,
	input wire refclk_detect,
	input wire [1:0] rx_parity_err,
	input wire cfg_load_done,
	input wire autoload_restart,
	input wire autoload_run,
	// Outputs under check
	input wire proxy_master_allow,
	input wire parity_check_en,
	input wire refclk_present,
	input wire lock_pin,
	input wire pass_pin,
	input wire csi_tx_hiz,
	input wire csi_tx_hs0,
	input wire csi_tx_lp11,
	input wire [1:0] parity_limit_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Control bits follow a configuration write two edges on
	cfg_apply_a: assert property (
		lcl_req && lcl_write && lcl_addr == 8'h02 |=> ##1
		($past(lcl_wdata, 2) & 8'h22) ==
		{2'h0, proxy_master_allow, 3'h0, parity_check_en, 1'h0})
		else $error("config bits not applied");
	// Both hosts are answered on the next edge when alone
	lcl_answer_a: assert property (
		lcl_req |=> lcl_ack) else $error("local ack missing");
	rmt_answer_a: assert property (
		rmt_req && !lcl_req |=> rmt_ack) else $error("remote ack missing");
	// Pins pass a two flop synchroniser and an output flop
	lock_follow_a: assert property (
		rx_lock != 2'h0 |-> ##3 lock_pin) else $error("lock pin late");
	ref_follow_a: assert property (
		refclk_detect |-> ##3 refclk_present) else $error("refclk late");
	pass_lock_a: assert property (
		pass_pin |-> lock_pin) else $error("pass without lock");
	// Output drive states never overlap
	csi_state_a: assert property (
		$onehot0({csi_tx_hiz, csi_tx_hs0, csi_tx_lp11}))
		else $error("csi states overlap");
	// The port 0 limit flag only rises after a counted error
	flag_cause_a: assert property (
		$rose(parity_limit_flag[0]) |-> $past(rx_parity_err[0], 2))
		else $error("flag without error");
	// Loader run level ends on done and restarts on request
	load_end_a: assert property (
		cfg_load_done && autoload_run |=> !autoload_run)
		else $error("load not ended");
	load_restart_a: assert property (
		autoload_restart && !autoload_run |=> autoload_run)
		else $error("restart ignored");
	// Main scenarios reached
	cover property (lcl_req && !lcl_write ##1 lcl_ack);
	cover property ($rose(parity_limit_flag[0]));
	cover property ($rose(csi_tx_hs0));
endmodule
bind dgcs_top dgcs_top_sva dgcs_top_sva_inst (.clk(clk), .reset(reset),
	.lcl_req(lcl_req), .lcl_write(lcl_write), .lcl_addr(lcl_addr),
	.lcl_wdata(lcl_wdata), .lcl_ack(lcl_ack), .rmt_req(rmt_req),
	.rmt_ack(rmt_ack), .rx_lock(rx_lock), .refclk_detect(refclk_detect),
	.rx_parity_err(rx_parity_err), .cfg_load_done(cfg_load_done),
	.autoload_restart(autoload_restart), .autoload_run(autoload_run),
	.proxy_master_allow(proxy_master_allow),
	.parity_check_en(parity_check_en), .refclk_present(refclk_present),
	.lock_pin(lock_pin), .pass_pin(pass_pin), .csi_tx_hiz(csi_tx_hiz),
	.csi_tx_hs0(csi_tx_hs0), .csi_tx_lp11(csi_tx_lp11),
	.parity_limit_flag(parity_limit_flag));

//--- test/dgcs_rmt_host.sv
// Remote host model on the control channel register port
`timescale 1ns/1ps
module dgcs_rmt_host (
	// Clock
	input wire clk,
	// Remote register port
	output reg rmt_req,
	output reg rmt_write,
	output reg [7:0] rmt_addr,
	output reg [7:0] rmt_wdata,
	input wire rmt_ack
);
	integer n;
	// Idle state at time zero
	initial begin
		rmt_req = 1'b0;
		rmt_write = 1'b0;
		rmt_addr = 8'h00;
		rmt_wdata = 8'h00;
	end
	// one access, after gap idle cycles to vary the pace
	task xfer(input w, input [7:0] a, input [7:0] d, input integer gap);
		begin
			repeat (gap) @(posedge clk);
			rmt_req <= 1'b1;
			rmt_write <= w;
			rmt_addr <= a;
			rmt_wdata <= d;
			@(posedge clk);
			rmt_req <= 1'b0;
			n = 0;
			while (rmt_ack !== 1'b1 && n < 8) begin
				@(posedge clk);
				n = n + 1;
			end
			// Released lines show no stale value
			rmt_addr <= ~a;
			rmt_wdata <= ~d;
		end
	endtask
endmodule

//--- test/tb_dgcs_top.sv
// Self-checking bench for the configuration and status register bank
`timescale 1ns/1ps
module tb_dgcs_top;
	reg clk, reset, lcl_req, lcl_write, refclk_detect, refclk_div, ref_on;
	reg [7:0] lcl_addr, lcl_wdata, lfsr;
	reg [1:0] rx_lock, rx_pass, rx_parity_err, rx_status_clear;
	reg [1:0] csi_port_assign;
	reg autoload_restart, cfg_load_done, cfg_cksum_ok;
	wire lcl_ack, rmt_req, rmt_write, rmt_ack, autoload_run;
	wire [7:0] lcl_rdata, rmt_addr, rmt_wdata, rmt_rdata;
	wire proxy_master_allow, parity_check_en, refclk_present, lock_pin;
	wire pass_pin, csi_tx_hiz, csi_tx_hs0, csi_tx_lp11;
	wire [1:0] parity_limit_flag;
	reg [8:0] lq[$];
	reg [8:0] rq[$];
	reg [8:0] x, y;
	reg [31:0] pol_cfg;
	reg [11:0] pol_exp;
	integer fail_count, cmp_count, cyc, i;
	// Revision nibble; value is arbitrary
	localparam [3:0] SREV = 4'ha;
	dgcs_top #(.SILICON_REV(SREV)) dgcs_top_inst (.clk(clk), .reset(reset),
		.lcl_req(lcl_req), .lcl_write(lcl_write), .lcl_addr(lcl_addr),
		.lcl_wdata(lcl_wdata), .lcl_ack(lcl_ack), .lcl_rdata(lcl_rdata),
		.rmt_req(rmt_req), .rmt_write(rmt_write), .rmt_addr(rmt_addr),
		.rmt_wdata(rmt_wdata), .rmt_ack(rmt_ack), .rmt_rdata(rmt_rdata),
		.rx_lock(rx_lock), .rx_pass(rx_pass), .refclk_detect(refclk_detect),
		.refclk_div(refclk_div), .rx_parity_err(rx_parity_err),
		.rx_status_clear(rx_status_clear), .csi_port_assign(csi_port_assign),
		.autoload_restart(autoload_restart), .cfg_load_done(cfg_load_done),
		.cfg_cksum_ok(cfg_cksum_ok), .autoload_run(autoload_run),
		.proxy_master_allow(proxy_master_allow),
		.parity_check_en(parity_check_en), .refclk_present(refclk_present),
		.lock_pin(lock_pin), .pass_pin(pass_pin), .csi_tx_hiz(csi_tx_hiz),
		.csi_tx_hs0(csi_tx_hs0), .csi_tx_lp11(csi_tx_lp11),
		.parity_limit_flag(parity_limit_flag));
	dgcs_rmt_host dgcs_rmt_host_inst (.clk(clk), .rmt_req(rmt_req),
		.rmt_write(rmt_write), .rmt_addr(rmt_addr), .rmt_wdata(rmt_wdata),
		.rmt_ack(rmt_ack));
	// Clock, and a divided reference clock kept off the clock edges
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		refclk_div = 1'b0;
		#7;
		forever #80 if (ref_on) refclk_div = ~refclk_div;
	end
	function [7:0] nxt(input [7:0] s);
		nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task chk8(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch at %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Local access; the read expectation goes to the queue
	task acc(input w, input [7:0] a, input [7:0] d);
		begin
			lq.push_back({~w, d});
			lcl_req <= 1'b1;
			lcl_write <= w;
			lcl_addr <= a;
			lcl_wdata <= d;
			@(posedge clk);
			lcl_req <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task rmt(input w, input [7:0] a, input [7:0] d);
		begin
			rq.push_back({~w, d});
			dgcs_rmt_host_inst.xfer(w, a, d, 2);
		end
	endtask
	task pulse_err(input [1:0] p);
		begin
			rx_parity_err <= p;
			@(posedge clk);
			rx_parity_err <= 2'h0;
			repeat (3) @(posedge clk);
		end
	endtask
	task complete_run;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Answer checkers pop the oldest note on each acknowledge
	always @(posedge clk) begin
		if (lcl_ack === 1'b1) begin
			x = lq.pop_front();
			if (x[8]) chk8(lcl_rdata, x[7:0]);
		end
		if (rmt_ack === 1'b1) begin
			y = rq.pop_front();
			if (y[8]) chk8(rmt_rdata, y[7:0]);
		end
	end
	// Hang guard sized well above the sequence length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fail_count = fail_count + 1;
			complete_run;
		end
	end
	initial begin
		fail_count = 0;
		cmp_count = 0;
		cyc = 0;
		reset = 1'b1;
		{lcl_req, lcl_write, lcl_addr, lcl_wdata} = 18'h0;
		{rx_lock, rx_pass, rx_parity_err, rx_status_clear} = 8'h0;
		{refclk_detect, ref_on, autoload_restart, cfg_load_done} = 4'h0;
		cfg_cksum_ok = 1'b0;
		csi_port_assign = 2'h1;
		lfsr = 8'h2b;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		acc(0, 8'h02, 8'h1e);
		acc(0, 8'h05, 8'h01);
		acc(0, 8'h06, 8'h00);
		acc(0, 8'h40, 8'h00);
		acc(1, 8'h03, 8'hff);
		acc(0, 8'h03, {SREV, 4'h0});
		acc(1, 8'h04, 8'hff);
		acc(0, 8'h04, 8'h03);
		// Loader done with good then bad checksum around a restart
		cfg_cksum_ok <= 1'b1;
		cfg_load_done <= 1'b1;
		@(posedge clk);
		cfg_load_done <= 1'b0;
		acc(0, 8'h04, 8'hc3);
		autoload_restart <= 1'b1;
		@(posedge clk);
		autoload_restart <= 1'b0;
		acc(0, 8'h04, 8'h03);
		cfg_cksum_ok <= 1'b0;
		cfg_load_done <= 1'b1;
		@(posedge clk);
		cfg_load_done <= 1'b0;
		acc(0, 8'h04, 8'h43);
		// Random threshold bytes through both hosts
		for (i = 0; i < 4; i = i + 1) begin
			lfsr = nxt(lfsr);
			acc(1, 8'h05, lfsr);
			rmt(0, 8'h05, lfsr);
			rmt(1, 8'h06, ~lfsr);
			acc(0, 8'h06, ~lfsr);
		end
		// Local and remote meet on one edge; remote waits a cycle
		fork
			begin
				repeat (2) @(posedge clk);
				acc(0, 8'h05, lfsr);
			end
			rmt(0, 8'h06, ~lfsr);
		join
		// Threshold of three on a live low byte
		acc(1, 8'h05, 8'h00);
		acc(1, 8'h06, 8'h03);
		for (i = 0; i < 3; i = i + 1) begin
			chk8({6'h0, parity_limit_flag}, 8'h00);
			pulse_err(2'h1);
		end
		chk8({6'h0, parity_limit_flag}, 8'h01);
		rx_status_clear <= 2'h3;
		acc(1, 8'h02, 8'h1c);
		rx_status_clear <= 2'h0;
		for (i = 0; i < 3; i = i + 1) pulse_err(2'h3);
		chk8({5'h0, parity_limit_flag, parity_check_en}, 8'h00);
		acc(1, 8'h02, 8'h3f);
		@(posedge clk);
		chk8({5'h0, proxy_master_allow, parity_check_en, refclk_present},
			8'h07);
		acc(1, 8'h02, 8'h1e);
		@(posedge clk);
		chk8({6'h0, proxy_master_allow, refclk_present}, 8'h00);
		refclk_detect <= 1'b1;
		repeat (4) @(posedge clk);
		chk8({7'h0, refclk_present}, 8'h01);
		// Output policy table with no receiver locked
		pol_cfg = 32'h1e160e1a;
		pol_exp = 12'b001100100010;
		for (i = 0; i < 4; i = i + 1) begin
			acc(1, 8'h02, pol_cfg[8 * i +: 8]);
			repeat (3) @(posedge clk);
			chk8({5'h0, csi_tx_hiz, csi_tx_hs0, csi_tx_lp11},
				{5'h0, pol_exp[3 * i +: 3]});
		end
		rx_lock <= 2'h1;
		rx_pass <= 2'h1;
		repeat (5) @(posedge clk);
		chk8({3'h0, csi_tx_hiz, csi_tx_hs0, csi_tx_lp11, lock_pin,
			pass_pin}, 8'h03);
		acc(0, 8'h04, 8'h4f);
		ref_on <= 1'b1;
		repeat (1100) @(posedge clk);
		acc(0, 8'h04, 8'h5f);
		ref_on <= 1'b0;
		repeat (1100) @(posedge clk);
		acc(0, 8'h04, 8'h4f);
		complete_run;
	end
endmodule
